/* design/isc_arbiter.sv */
// Purpose: pick the highest priority pending source
// Assumes: requests already gated by mask and mode
// Notes: lower index wins among equal priorities
`timescale 1ns/10ps
`default_nettype none
module isc_arbiter
(
	input wire logic [isc_pkg::NREG-1:0] req_in,
	input wire isc_pkg::isc_ctrl_type ctrl_in [isc_pkg::NREG],
	output var isc_pkg::isc_win_type win_out
);
	always_comb
	begin
		win_out = '0;
		for (int i = 0; i < isc_pkg::NREG; i++)
		begin
			// strict compare keeps the earlier index on a tie
			if (req_in[i] && (!win_out.valid ||
				ctrl_in[i].priority_level < win_out.prio))
			begin
				win_out.valid = 1'b1;
				win_out.idx = isc_pkg::isc_idx_type'(i);
				win_out.prio = ctrl_in[i].priority_level;
			end
		end
	end
endmodule : isc_arbiter
`default_nettype wire

/* design/isc_top.sv */
// Purpose: per-source interrupt mask, priority and trigger control
// Assumes: register port with read data one cycle after the strobe
// Notes: master and slave register sets share offsets by mode
`timescale 1ns/10ps
`default_nettype none
module isc_top
(
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [isc_pkg::AW-1:0] addr_in,
	input wire logic [isc_pkg::DW-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [isc_pkg::DW-1:0] rdata_out,
	input wire logic [isc_pkg::NEXT-1:0] ext_request_in,
	input wire logic [isc_pkg::NTMR-1:0] timer_req_in,
	input wire logic [isc_pkg::NSP-1:0] serial_req_in,
	input wire logic ack_in,
	output logic [isc_pkg::NCAS-1:0] request_ack_out,
	output logic [isc_pkg::NCAS-1:0] request_ack_oe_out,
	output logic win_valid_out,
	output logic [isc_pkg::TYPE_W-1:0] win_type_out,
	output logic [isc_pkg::PW-1:0] win_prio_out,
	output logic [isc_pkg::PV_W-1:0] pend_out,
	output logic [isc_pkg::NCAS-1:0] cascade_out,
	output logic [isc_pkg::NCAS-1:0] special_nested_out,
	output logic slave_mode_out
);
	isc_pkg::isc_ctrl_type ctrl_q [isc_pkg::NREG];
	isc_pkg::isc_win_type win;
	isc_pkg::isc_win_type win_q;
	logic [isc_pkg::NREG-1:0] act;
	logic [isc_pkg::NREG-1:0] raw;
	logic [isc_pkg::NREG-1:0] mskv;
	logic [isc_pkg::NREG-1:0] gated;
	logic [isc_pkg::NEXT-1:0] ext_en;
	logic [isc_pkg::NEXT-1:0] ext_ack;
	logic [isc_pkg::NEXT-1:0] ext_req;
	logic [isc_pkg::PV_W-1:0] pend_d;
	logic [isc_pkg::PV_W-1:0] pend_q;
	logic [isc_pkg::PV_W-1:0] mview;
	logic [isc_pkg::DW-1:0] rd_d;
	logic [isc_pkg::DW-1:0] rdata_q;
	logic [isc_pkg::TYPE_W-1:0] type_q;
	logic [isc_pkg::NCAS-1:0] ack_q;
	logic [isc_pkg::NCAS-1:0] oe_q;
	logic [isc_pkg::NCAS-1:0] cas_q;
	logic [isc_pkg::NCAS-1:0] sfn_q;
	logic slave_q;
	logic casc0;
	logic casc1;
	logic rst_ok;
	logic beat;

	assign casc0 = ctrl_q[isc_pkg::R_EXT0].cas_en;
	assign casc1 = ctrl_q[isc_pkg::R_EXT1].cas_en;

	// mode register
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			slave_q <= 1'b0;
		end
		else if (wr_in && addr_in == isc_pkg::A_MODE)
		begin
			slave_q <= wdata_in[0];
		end
	end

	// per-register storage and visibility by mode
	for (genvar i = 0; i < isc_pkg::NREG; i++)
	begin : g_reg
		assign act[i] = (isc_pkg::MODE[i] == isc_pkg::M_BOTH) ||
			(isc_pkg::MODE[i] == isc_pkg::M_MASTER && !slave_q) ||
			(isc_pkg::MODE[i] == isc_pkg::M_SLAVE && slave_q);
		assign mskv[i] = ctrl_q[i].source_mask;

		always_ff @(posedge ref_clk_in)
		begin
			if (srst_in)
			begin
				ctrl_q[i] <= isc_pkg::isc_ctrl_type'(isc_pkg::RSTV[i]);
			end
			else if (wr_in && act[i] && addr_in == isc_pkg::OFFS[i])
			begin
				ctrl_q[i] <= isc_pkg::isc_ctrl_type'(
					(ctrl_q[i] & ~isc_pkg::WMSK[i]) |
					(wdata_in[isc_pkg::CW-1:0] & isc_pkg::WMSK[i]));
			end
			else if (wr_in && act[i] && addr_in == isc_pkg::A_IMASK)
			begin
				ctrl_q[i].source_mask <= wdata_in[isc_pkg::MPOS[i]];
			end
		end
	end

	// external pins: cascade takes pins 2 and 3, and pin 4 entirely
	assign ext_en[0] = !slave_q;
	assign ext_en[1] = !slave_q;
	assign ext_en[2] = !slave_q && !casc0;
	assign ext_en[3] = !slave_q && !casc1;
	assign ext_en[4] = !slave_q && !casc0 && !casc1;

	for (genvar p = 0; p < isc_pkg::NEXT; p++)
	begin : g_pin
		assign ext_ack[p] = ack_in && win_q.valid &&
			(win_q.idx == isc_pkg::isc_idx_type'(isc_pkg::EXT_REG[p]));

		isc_trigger u_trig
		(
			.ref_clk_in(ref_clk_in),
			.srst_in(srst_in),
			.pin_in(ext_request_in[p]),
			.level_mode_in(ctrl_q[isc_pkg::EXT_REG[p]].level_trigger_select),
			.enable_in(ext_en[p]),
			.ack_in(ext_ack[p]),
			.req_out(ext_req[p])
		);
	end

	// raw request per register slot
	always_comb
	begin
		raw = '0;
		raw[isc_pkg::R_TCU] = |timer_req_in;
		raw[isc_pkg::R_T0S] = timer_req_in[isc_pkg::TB0];
		raw[isc_pkg::R_T1S] = timer_req_in[isc_pkg::TB1];
		raw[isc_pkg::R_T2S] = timer_req_in[isc_pkg::TB2];
		raw[isc_pkg::R_SP1] = serial_req_in[isc_pkg::SPB1];
		raw[isc_pkg::R_SP0] = serial_req_in[isc_pkg::SPB0];
		for (int p = 0; p < isc_pkg::NEXT; p++)
		begin
			raw[isc_pkg::EXT_REG[p]] = ext_req[p];
		end
	end

	// mask 0 lets the source through, 1 blocks it
	assign gated = raw & act & ~mskv;

	// mask view and pending view share one bit layout
	always_comb
	begin
		pend_d = '0;
		mview = '0;
		for (int i = 0; i < isc_pkg::NREG; i++)
		begin
			if (act[i])
			begin
				pend_d[isc_pkg::MPOS[i]] = gated[i];
				mview[isc_pkg::MPOS[i]] = ctrl_q[i].source_mask;
			end
		end
	end

	isc_arbiter u_arb
	(
		.req_in(gated),
		.ctrl_in(ctrl_q),
		.win_out(win)
	);

	// registered resolution result
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			win_q <= '0;
			type_q <= '0;
			pend_q <= '0;
		end
		else
		begin
			win_q <= win;
			type_q <= isc_pkg::TYPES[win.idx];
			pend_q <= pend_d;
		end
	end

	// cascade acknowledge pins and mode outputs
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			ack_q <= '0;
			oe_q <= '0;
			cas_q <= '0;
			sfn_q <= '0;
		end
		else
		begin
			ack_q[0] <= ext_ack[0] && casc0;
			ack_q[1] <= ext_ack[1] && casc1;
			oe_q <= {casc1, casc0};
			cas_q <= {casc1, casc0};
			sfn_q <= {ctrl_q[isc_pkg::R_EXT1].special_nested_enable,
				ctrl_q[isc_pkg::R_EXT0].special_nested_enable};
		end
	end

	// read mux
	always_comb
	begin
		rd_d = '0;
		for (int i = 0; i < isc_pkg::NREG; i++)
		begin
			if (act[i] && addr_in == isc_pkg::OFFS[i])
			begin
				rd_d = isc_pkg::isc_word_type'(ctrl_q[i]);
			end
		end
		if (addr_in == isc_pkg::A_IMASK)
		begin
			rd_d = isc_pkg::isc_word_type'(mview);
		end
		if (addr_in == isc_pkg::A_MODE)
		begin
			rd_d = isc_pkg::isc_word_type'(slave_q);
		end
		if (addr_in == isc_pkg::A_PEND)
		begin
			rd_d = isc_pkg::isc_word_type'(pend_q);
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			rdata_q <= '0;
		end
		else
		begin
			rdata_q <= rd_in ? rd_d : '0;
		end
	end

	assign rdata_out = rdata_q;
	assign request_ack_out = ack_q;
	assign request_ack_oe_out = oe_q;
	assign win_valid_out = win_q.valid;
	assign win_type_out = type_q;
	assign win_prio_out = win_q.prio;
	assign pend_out = pend_q;
	assign cascade_out = cas_q;
	assign special_nested_out = sfn_q;
	assign slave_mode_out = slave_q;

	// checking helpers
	always_comb
	begin
		rst_ok = 1'b1;
		beat = 1'b0;
		for (int i = 0; i < isc_pkg::NREG; i++)
		begin
			if (ctrl_q[i] != isc_pkg::isc_ctrl_type'(isc_pkg::RSTV[i]))
			begin
				rst_ok = 1'b0;
			end
			if (gated[i] && (ctrl_q[i].priority_level < win.prio ||
				(ctrl_q[i].priority_level == win.prio &&
				isc_pkg::isc_idx_type'(i) < win.idx)))
			begin
				beat = 1'b1;
			end
		end
	end

	reset_values_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in) $past(srst_in) |-> rst_ok)
		else $error("control registers not at reset values");

	sp_mask_gate_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		(ctrl_q[isc_pkg::R_SP0].source_mask ||
		serial_req_in[isc_pkg::SPB0]) |=>
		pend_q[isc_pkg::MPOS[isc_pkg::R_SP0]] ==
		!$past(ctrl_q[isc_pkg::R_SP0].source_mask))
		else $error("serial 0 pending does not follow mask");

	ext4_mask_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		ctrl_q[isc_pkg::R_EXT4].source_mask |=>
		!pend_q[isc_pkg::MPOS[isc_pkg::R_EXT4]])
		else $error("masked pin 4 shows pending");

	ext4_cascade_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		(casc0 || casc1) |=> !pend_q[isc_pkg::MPOS[isc_pkg::R_EXT4]])
		else $error("pin 4 active in cascade");

	timer_or_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		(!slave_q && !ctrl_q[isc_pkg::R_TCU].source_mask &&
		|timer_req_in) |=> pend_q[isc_pkg::MPOS[isc_pkg::R_TCU]])
		else $error("combined timer request lost");

	mask_mirror_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		(wr_in && addr_in == isc_pkg::A_IMASK && !slave_q) |=>
		ctrl_q[isc_pkg::R_EXT2].source_mask ==
		$past(wdata_in[isc_pkg::MPOS[isc_pkg::R_EXT2]]))
		else $error("mask register write not mirrored");

	casc_ack_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		(ext_ack[0] && casc0) |=> (request_ack_out[0] && request_ack_oe_out[0])
		##1 !request_ack_out[0])
		else $error("cascade acknowledge 0 not pulsed");

	win_type_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		(win.valid && win.idx == isc_pkg::isc_idx_type'(isc_pkg::R_EXT3)) |=>
		(win_valid_out && win_type_out == isc_pkg::TYPES[isc_pkg::R_EXT3]))
		else $error("wrong type number for pin 3");

	tie_order_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		(|gated) |=> (win_valid_out && !$past(beat)))
		else $error("arbitration order broken");

	casc_pin2_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		casc0 |=> !pend_q[isc_pkg::MPOS[isc_pkg::R_EXT2]])
		else $error("pin 2 pending while it acknowledges");

	tcu_mask_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		(!slave_q && ctrl_q[isc_pkg::R_TCU].source_mask) |=>
		!pend_q[isc_pkg::MPOS[isc_pkg::R_TCU]])
		else $error("masked timer unit shows pending");

	ext0_type_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		(win.valid && win.idx == isc_pkg::isc_idx_type'(isc_pkg::R_EXT0)) |=>
		(win_valid_out && win_type_out == isc_pkg::TYPES[isc_pkg::R_EXT0]))
		else $error("wrong type number for pin 0");

	slave_pins_off_a: assert property (@(posedge ref_clk_in)
		disable iff (srst_in)
		slave_q |=> !pend_q[isc_pkg::MPOS[isc_pkg::R_EXT2]])
		else $error("external pin pending in slave mode");
endmodule : isc_top
`default_nettype wire

/* design/isc_trigger.sv */
// Purpose: synchronise one request pin and apply edge or level sensing
// Assumes: pin is asynchronous to ref_clk_in
// Notes: edge latch is cleared by acknowledge; a new edge wins
`timescale 1ns/10ps
`default_nettype none
module isc_trigger
(
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic pin_in,
	input wire logic level_mode_in,
	input wire logic enable_in,
	input wire logic ack_in,
	output logic req_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic filt_q;
	logic edge_q;
	logic rise;

	assign rise = (s2_q == s3_q) && s3_q && !filt_q;

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			filt_q <= 1'b0;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
			begin
				filt_q <= s3_q;
			end
		end
	end

	// rising edge latch, set wins over acknowledge
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in || !enable_in || level_mode_in)
		begin
			edge_q <= 1'b0;
		end
		else if (rise)
		begin
			edge_q <= 1'b1;
		end
		else if (ack_in)
		begin
			edge_q <= 1'b0;
		end
	end

	// level mode relies on the source holding the line
	assign req_out = enable_in && (level_mode_in ? filt_q : edge_q);

	edge_catch_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(enable_in && !level_mode_in && $rose(filt_q)) |-> req_out)
		else $error("rising edge not latched");

	level_follow_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(level_mode_in && enable_in && s2_q == s3_q) ##1
		(level_mode_in && enable_in) |-> (req_out == $past(s3_q)))
		else $error("level request does not follow pin");
endmodule : isc_trigger
`default_nettype wire

/* inc/isc_pkg.sv */
// Purpose: constants and types for the interrupt source control bank
// Assumes: 16-bit registers at their byte offsets, one 125 MHz clock
// Notes: register index order is also the equal-priority order
// Behaviour
// - serial mask bit 0 enables, 1 blocks
// - serial control registers reset to 001Fh
// - three-bit priority, 0 highest, resets to 7
// - pin 4 unusable while cascade selected
// - pin 4 trigger bit: 1 level, 0 edge
// - pin 4 register resets masked, lowest, edge
// - pin 4 raises requests only when unmasked
// - pins 2 and 3 use types 0Eh, 0Fh
// - cascade turns pins 2, 3 into acknowledges
// - pins 2, 3 trigger bit: 1 level, 0 edge
// - mask bits mirrored in the mask register
// - pins 0 and 1 use types 0Ch, 0Dh
// - pins 0, 1 have nested and cascade enables
// - pins 0, 1 trigger bit: 1 level, 0 edge
// - master mode: one timer register, type 08h
// - master mode: timer mask bit gates all timer sources
// - slave mode: one register per timer, reset 000Fh
// - combined timer request is OR of three
`default_nettype none
package isc_pkg;
	localparam int NREG = 11;
	localparam int AW = 8;
	localparam int DW = 16;
	localparam int CW = 7;
	localparam int PW = 3;
	localparam int PV_W = 11;
	localparam int TYPE_W = 8;
	localparam int NEXT = 5;
	localparam int NTMR = 3;
	localparam int NSP = 2;
	localparam int NCAS = 2;
	localparam int TB0 = 0;
	localparam int TB1 = 1;
	localparam int TB2 = 2;
	localparam int SPB0 = 0;
	localparam int SPB1 = 1;
	localparam int R_TCU = 0;
	localparam int R_T0S = 1;
	localparam int R_EXT0 = 2;
	localparam int R_T1S = 3;
	localparam int R_EXT1 = 4;
	localparam int R_T2S = 5;
	localparam int R_EXT2 = 6;
	localparam int R_EXT3 = 7;
	localparam int R_EXT4 = 8;
	localparam int R_SP1 = 9;
	localparam int R_SP0 = 10;
	localparam logic [1:0] M_BOTH = 2'h0;
	localparam logic [1:0] M_MASTER = 2'h1;
	localparam logic [1:0] M_SLAVE = 2'h2;
	localparam logic [AW-1:0] A_IMASK = 8'h28;
	localparam logic [AW-1:0] A_MODE = 8'h46;
	localparam logic [AW-1:0] A_PEND = 8'h48;
	localparam logic [AW-1:0] OFFS [NREG] = '{8'h32, 8'h32, 8'h38, 8'h38,
		8'h3A, 8'h3A, 8'h3C, 8'h3E, 8'h40, 8'h42, 8'h44};
	localparam logic [1:0] MODE [NREG] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1,
		2'h2, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0};
	localparam logic [CW-1:0] RSTV [NREG] = '{7'h0F, 7'h0F, 7'h0F, 7'h0F,
		7'h0F, 7'h0F, 7'h0F, 7'h0F, 7'h0F, 7'h1F, 7'h1F};
	localparam logic [CW-1:0] WMSK [NREG] = '{7'h0F, 7'h0F, 7'h7F, 7'h0F,
		7'h7F, 7'h0F, 7'h1F, 7'h1F, 7'h1F, 7'h0F, 7'h0F};
	localparam int MPOS [NREG] = '{0, 0, 4, 4, 5, 5, 6, 7, 8, 9, 10};
	localparam logic [TYPE_W-1:0] TYPES [NREG] = '{8'h08, 8'h08, 8'h0C,
		8'h12, 8'h0D, 8'h13, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h14};
	localparam int EXT_REG [NEXT] = '{2, 4, 6, 7, 8};
	localparam logic [PW-1:0] PRIO_LOW = 3'h7;
	typedef logic [3:0] isc_idx_type;
	typedef logic [DW-1:0] isc_word_type;
	typedef struct packed {
		logic special_nested_enable;
		logic cas_en;
		logic level_trigger_select;
		logic source_mask;
		logic [PW-1:0] priority_level;
	} isc_ctrl_type;
	typedef struct packed {
		logic valid;
		isc_idx_type idx;
		logic [PW-1:0] prio;
	} isc_win_type;
endpackage : isc_pkg
`default_nettype wire

/* sim/isc_src_model.sv */
// Purpose: external request sources facing the interrupt source bank
// Assumes: one clock, stimulus changes right after rising edges
// Notes: a request stays high until acknowledged and no longer wanted
`timescale 1ns/10ps
`default_nettype none
module isc_src_model
(
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [4:0] want_in,
	input wire logic ack_in,
	input wire logic [7:0] win_type_in,
	output logic [4:0] ext_request_out
);
	logic [4:0] req_q;
	logic [4:0] done;
	always_comb
	begin
		for (int i = 0; i < 5; i++)
			done[i] = ack_in && win_type_in == 8'h0C + 8'(i) && !want_in[i];
	end
	// a source only lets go once its request was acknowledged
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			req_q <= '0;
		else
			req_q <= (req_q | want_in) & ~done;
	end
	assign ext_request_out = req_q;
endmodule : isc_src_model
`default_nettype wire

/* sim/isc_top_tb.sv */
// Purpose: self-checking bench for the interrupt source bank
// Assumes: register port answers one cycle after the read strobe
// Notes: each scenario starts from a fresh reset
`timescale 1ns/10ps
`default_nettype none
module isc_top_tb;
	logic ref_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [15:0] wdata_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [4:0] want = 5'h00;
	logic [2:0] timer_req = 3'h0;
	logic [1:0] serial_req = 2'h0;
	logic ack_in = 1'b0;
	logic [4:0] ext_req;
	logic [15:0] rdata_out;
	logic [1:0] req_ack, req_ack_oe, cascade, nested;
	logic win_valid_out, slave_mode;
	logic [7:0] win_type_out;
	logic [2:0] win_prio_out;
	logic [10:0] pend_out;
	int errors = 0;
	int n_tests = 0;
	logic [7:0] pin_addr [5] = '{8'h38, 8'h3A, 8'h3C, 8'h3E, 8'h40};
	always #4 ref_clk_in = ~ref_clk_in;
	isc_src_model u_isc_src_model (.ref_clk_in(ref_clk_in),
		.srst_in(srst_in), .want_in(want), .ack_in(ack_in),
		.win_type_in(win_type_out), .ext_request_out(ext_req));
	isc_top u_isc_top (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .ext_request_in(ext_req),
		.timer_req_in(timer_req), .serial_req_in(serial_req),
		.ack_in(ack_in), .request_ack_out(req_ack),
		.request_ack_oe_out(req_ack_oe), .win_valid_out(win_valid_out),
		.win_type_out(win_type_out), .win_prio_out(win_prio_out),
		.pend_out(pend_out), .cascade_out(cascade),
		.special_nested_out(nested), .slave_mode_out(slave_mode));
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rst(input int n);
		@(posedge ref_clk_in);
		srst_in <= 1'b1;
		want <= 5'h00;
		timer_req <= 3'h0;
		serial_req <= 2'h0;
		repeat (n) @(posedge ref_clk_in);
		srst_in <= 1'b0;
	endtask : rst
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge ref_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), e, rdata_out);
	endtask : rd
	task automatic st;
		repeat (8) @(posedge ref_clk_in);
		#1;
	endtask : st
	task automatic w(input logic v, input logic [7:0] t, input logic [2:0] p);
		chk("win_valid", 16'(v), 16'(win_valid_out));
		if (v)
		begin
			chk("win_type", 16'(t), 16'(win_type_out));
			chk("win_prio", 16'(p), 16'(win_prio_out));
		end
	endtask : w
	task automatic ack;
		@(posedge ref_clk_in);
		ack_in <= 1'b1;
		@(posedge ref_clk_in);
		ack_in <= 1'b0;
		#1;
	endtask : ack
	task automatic t_reset;
		rst(2);
		for (int i = 0; i < 6; i++)
			rd(i == 5 ? 8'h32 : pin_addr[i], 16'h000F);
		rd(8'h42, 16'h001F);
		rd(8'h44, 16'h001F);
		rd(8'h30, 16'h0000);
		wr(8'h40, 16'hFFFF);
		rd(8'h40, 16'h001F);
		st;
		w(1'b0, 8'h00, 3'h0);
	endtask : t_reset
	task automatic t_serial;
		rst(2);
		wr(8'h44, 16'h0002);
		rd(8'h44, 16'h0012);
		serial_req <= 2'h3;
		st;
		w(1'b1, 8'h14, 3'h2);
		wr(8'h42, 16'h0002);
		st;
		w(1'b1, 8'h11, 3'h2);
		wr(8'h42, 16'h000A);
		wr(8'h44, 16'h000A);
		st;
		w(1'b0, 8'h00, 3'h0);
	endtask : t_serial
	task automatic t_timer;
		rst(2);
		wr(8'h32, 16'h0003);
		timer_req <= 3'h4;
		st;
		w(1'b1, 8'h08, 3'h3);
		chk("pend_tmr", 16'h0001, 16'(pend_out[0]));
		wr(8'h44, 16'h0001);
		serial_req <= 2'h1;
		st;
		w(1'b1, 8'h14, 3'h1);
		wr(8'h32, 16'h0001);
		st;
		w(1'b1, 8'h08, 3'h1);
		wr(8'h32, 16'h0009);
		st;
		w(1'b1, 8'h14, 3'h1);
		wr(8'h28, 16'h0000);
		rd(8'h32, 16'h0001);
	endtask : t_timer
	task automatic t_pins;
		for (int i = 0; i < 5; i++)
		begin
			rst(2);
			wr(pin_addr[i], 16'h0010 + 16'(i));
			want[i] <= 1'b1;
			st;
			w(1'b1, 8'h0C + 8'(i), 3'(i));
			ack;
			st;
			w(1'b1, 8'h0C + 8'(i), 3'(i));
		end
		want[4] <= 1'b0;
		ack;
		st;
		wr(8'h40, 16'h0002);
		want[4] <= 1'b1;
		st;
		w(1'b1, 8'h10, 3'h2);
		want[4] <= 1'b0;
		ack;
		st;
		w(1'b0, 8'h00, 3'h0);
		wr(8'h28, 16'h0100);
		rd(8'h40, 16'h000A);
	endtask : t_pins
	task automatic t_cascade;
		rst(2);
		wr(8'h38, 16'h0060);
		wr(8'h40, 16'h0010);
		want <= 5'h10;
		st;
		chk("ack_oe", 16'h0001, 16'(req_ack_oe));
		chk("cascade", 16'h0001, 16'(cascade));
		chk("nested", 16'h0001, 16'(nested));
		w(1'b0, 8'h00, 3'h0);
		want <= 5'h01;
		st;
		w(1'b1, 8'h0C, 3'h0);
		ack;
		chk("ack_pin", 16'h0001, 16'(req_ack));
		@(posedge ref_clk_in);
		#1;
		chk("ack_pin", 16'h0000, 16'(req_ack));
	endtask : t_cascade
	task automatic t_slave;
		rst(2);
		wr(8'h46, 16'h0001);
		rd(8'h32, 16'h000F);
		rd(8'h38, 16'h000F);
		rd(8'h3A, 16'h000F);
		chk("slave", 16'h0001, 16'(slave_mode));
		wr(8'h38, 16'h0000);
		timer_req <= 3'h2;
		st;
		w(1'b1, 8'h12, 3'h0);
		wr(8'h3A, 16'h0001);
		timer_req <= 3'h5;
		st;
		w(1'b1, 8'h13, 3'h1);
	endtask : t_slave
	task automatic summarize;
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	initial
	begin
		rst(20);
		t_reset;
		t_serial;
		t_timer;
		t_pins;
		t_cascade;
		t_slave;
		summarize;
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk_in);
		errors++;
		summarize;
	end
endmodule : isc_top_tb
`default_nettype wire
